// >>> rtl/itrsi_top.sv
// How it works
// R1 - receive only when addressed with direction bit zero (controller writes)
// R2 - shift data MSB first on clock rises, copy to receive register after eight
// R3 - receive-ready flag bit 4 set on load, cleared by writing one
// R4 - without stretching software reads the byte within seven bus clocks
// R5 - with stretching, hold clock low until receive register is read
// R6 - unread byte overwritten by next one sets overflow bit 5, write-one clears
// R7 - acknowledge each byte low when nak select is zero, release when one
// R8 - software sets nak select within seven bus clocks of previous ready
// R9 - stop is data rising while clock high
// R10 - stop while addressed: flag bit 0, release lines, idle, clear addressed, busy
// R11 - stop flag stays set until software writes one
// R12 - repeated start while addressed also sets the stop flag
// R13 - software checks busy and addressed zero before leaving communication mode
// R14 - transmit interrupt on read request while transmit empty, drops on write
// R15 - transmit, receive, bus interrupts pass only when enables bits 0-2 set
// R16 - receive interrupt whenever ready flag rises on a byte load
// R17 - bus sources: async, underflow, nak, mismatch, overflow, bus free, stop; only mismatch, overflow and stop are built, the rest read zero
// R18 - any bus source sets summary bit 7 and asserts the interrupt
// R19 - mismatch when another target acknowledges our nak, never in async mode
// R20 - all enabled causes share one interrupt line
// R21 - busy set on start, addressed on own address, busy cleared on stop
// R22 - lines synchronised to the bus clock before edge and condition detection
`timescale 1ns/1ps
`default_nettype none
module itrsi_top (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [16:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // i2c lines, open drain
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    // shared interrupt
    output logic irq
);
    // ----------------------------------------
    // line sampling
    // ----------------------------------------
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_p;
    logic stop_p;
    itrsi_sync #(.W(2)) u_sync ( // [R22]
        .clk(pclk),
        .rst_n(presetn),
        .d({serial_clock_pin_in, serial_data_pin_in}),
        .q({scl_s, sda_s})
    );
    itrsi_linecond u_cond (
        .clk(pclk),
        .rst_n(presetn),
        .scl(scl_s),
        .sda(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_p(start_p),
        .stop_p(stop_p)
    );
    // ----------------------------------------
    // state
    // ----------------------------------------
    itrsi_pkg::itrsi_state_e state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] rx_q;
    logic [7:0] tx_q, tx_d;
    logic [6:0] own_q;
    logic [8:0] ctl_q, ctl_d;
    logic [2:0] ien_q;
    logic match_q, match_d;
    logic sda_oe_q, sda_oe_d;
    logic scl_oe_q, scl_oe_d;
    logic busy_q, busy_d;
    logic addressed_q, addressed_d;
    logic rw_q, rw_d;
    logic stop_seen_q, stop_seen_d;
    logic mism_q, mism_d;
    logic ovf_q, ovf_d;
    logic receive_ready_flag_q, receive_ready_flag_d;
    logic unread_q, unread_d;
    logic transmit_empty_flag_q, transmit_empty_flag_d;
    logic irq_d;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic stop_set;
    logic mism_set;
    logic transmit_empty_flag_set;
    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire setup_w = psel & ~penable;
    wire access_w = psel & penable & pready_q;
    wire wr_w = access_w & pwrite;
    wire rd_w = access_w & ~pwrite;
    wire sel_tx = (paddr[16:2] == itrsi_pkg::OFS_TRANSMIT[14:0]);
    wire sel_rx = (paddr[16:2] == itrsi_pkg::OFS_RECEIVE[14:0]);
    wire sel_own = (paddr[16:2] == itrsi_pkg::OFS_OWN_ADDR[14:0]);
    wire sel_ctl = (paddr[16:2] == itrsi_pkg::OFS_CONTROL[14:0]);
    wire sel_evt = (paddr[16:2] == itrsi_pkg::OFS_BUS_EVENT[14:0]);
    wire sel_ast = (paddr[16:2] == itrsi_pkg::OFS_ACCESS[14:0]);
    wire sel_ien = (paddr[16:2] == itrsi_pkg::OFS_IRQ_EN[14:0]);
    wire mapped = sel_tx | sel_rx | sel_own | sel_ctl | sel_evt | sel_ast | sel_ien;
    wire wr_tx = wr_w & sel_tx;
    wire wr_ctl = wr_w & sel_ctl;
    wire rd_rx = rd_w & sel_rx;
    wire [15:0] evt_clr = (wr_w & sel_evt) ? pwdata[15:0] : 16'h0000;
    wire [15:0] ast_clr = (wr_w & sel_ast) ? pwdata[15:0] : 16'h0000;
    wire [8:0] ctl_w = wr_ctl ? pwdata[8:0] : ctl_q;
    // protocol held in standby while disabled or in soft reset
    wire proto_off = ctl_q[itrsi_pkg::CTL_SOFTRST] | ~ctl_q[itrsi_pkg::CTL_ENABLE];
    wire own_match = ctl_q[itrsi_pkg::CTL_COMM] & (shift_q[7:1] == own_q);
    wire byte_done = scl_rise & (state_q == itrsi_pkg::ST_RX)
        & (cnt_q == itrsi_pkg::CNT_LAST_BIT);
    // unimplemented sources (async, controller nak, bus free) read zero
    wire summary = stop_seen_q | mism_q | ovf_q; // [R17]
    logic [15:0] evt_word;
    logic [15:0] ast_word;
    always_comb
    begin
        evt_word = 16'h0000;
        evt_word[itrsi_pkg::EVT_STOP] = stop_seen_q;
        evt_word[itrsi_pkg::EVT_MISMATCH] = mism_q;
        evt_word[itrsi_pkg::EVT_OVF] = ovf_q;
        evt_word[itrsi_pkg::EVT_SUMMARY] = summary; // [R18]
        ast_word = 16'h0000;
        ast_word[itrsi_pkg::AST_RW] = rw_q;
        ast_word[itrsi_pkg::AST_ADDRESSED] = addressed_q;
        ast_word[itrsi_pkg::AST_BUSY] = busy_q;
        ast_word[itrsi_pkg::AST_TRANSMIT_EMPTY_FLAG] = transmit_empty_flag_q;
        ast_word[itrsi_pkg::AST_RECEIVE_READY_FLAG] = receive_ready_flag_q;
    end
    wire [15:0] rd_word = sel_tx ? {8'h00, tx_q} :
        sel_rx ? {8'h00, rx_q} :
        sel_own ? {9'h000, own_q} :
        sel_ctl ? {7'h00, ctl_q} :
        sel_evt ? evt_word :
        sel_ast ? ast_word :
        sel_ien ? {13'h0000, ien_q} : 16'h0000;
    // ----------------------------------------
    // receive protocol
    // ----------------------------------------
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        match_d = match_q;
        sda_oe_d = sda_oe_q;
        scl_oe_d = scl_oe_q;
        busy_d = busy_q;
        addressed_d = addressed_q;
        rw_d = rw_q;
        stop_set = 1'b0;
        mism_set = 1'b0;
        transmit_empty_flag_set = 1'b0;
        if (scl_rise && (state_q == itrsi_pkg::ST_ADDR || state_q == itrsi_pkg::ST_RX))
        begin
            shift_d = {shift_q[6:0], sda_s}; // [R2]
            cnt_d = cnt_q + itrsi_pkg::CNT_ONE;
        end
        unique case (state_q)
            itrsi_pkg::ST_IDLE:
            begin
                state_d = itrsi_pkg::ST_IDLE;
            end
            itrsi_pkg::ST_ADDR:
            begin
                if (scl_fall && cnt_q == itrsi_pkg::CNT_BYTE)
                begin
                    match_d = own_match;
                    addressed_d = own_match; // [R21]
                    rw_d = own_match ? shift_q[0] : rw_q;
                    sda_oe_d = own_match;
                    state_d = itrsi_pkg::ST_ADDR_ACK;
                end
            end
            itrsi_pkg::ST_ADDR_ACK:
            begin
                // someone else acknowledged an address we left unanswered
                if (scl_rise && !match_q && !ctl_q[itrsi_pkg::CTL_ASYNC] && !sda_s)
                begin
                    mism_set = 1'b1; // [R19]
                end
                if (scl_fall)
                begin
                    sda_oe_d = 1'b0;
                    cnt_d = itrsi_pkg::CNT_ZERO;
                    state_d = (match_q && !rw_q) ? itrsi_pkg::ST_RX : itrsi_pkg::ST_HOLD; // [R1]
                    transmit_empty_flag_set = match_q & rw_q;
                end
            end
            itrsi_pkg::ST_RX:
            begin
                if (scl_fall && cnt_q == itrsi_pkg::CNT_BYTE)
                begin
                    state_d = itrsi_pkg::ST_RX_ACK;
                    sda_oe_d = ~ctl_q[itrsi_pkg::CTL_NAK]; // [R7]
                    scl_oe_d = ctl_q[itrsi_pkg::CTL_STRETCH] & unread_q; // [R5]
                end
            end
            itrsi_pkg::ST_RX_ACK:
            begin
                if (scl_oe_q && !unread_q)
                begin
                    scl_oe_d = 1'b0; // [R5]
                end
                if (scl_fall)
                begin
                    sda_oe_d = 1'b0;
                    cnt_d = itrsi_pkg::CNT_ZERO;
                    state_d = itrsi_pkg::ST_RX;
                end
            end
            itrsi_pkg::ST_HOLD:
            begin
                state_d = itrsi_pkg::ST_HOLD;
            end
            default:
            begin
                state_d = itrsi_pkg::ST_IDLE;
            end
        endcase
        if (start_p)
        begin
            stop_set = addressed_q; // [R12]
            addressed_d = 1'b0;
            busy_d = 1'b1; // [R21]
            state_d = itrsi_pkg::ST_ADDR;
            cnt_d = itrsi_pkg::CNT_ZERO;
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
        end
        if (stop_p)
        begin
            stop_set = addressed_q; // [R10]
            addressed_d = 1'b0;
            busy_d = 1'b0; // [R21]
            state_d = itrsi_pkg::ST_IDLE;
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
        end
        if (proto_off)
        begin
            stop_set = 1'b0;
            mism_set = 1'b0;
            transmit_empty_flag_set = 1'b0;
            state_d = itrsi_pkg::ST_IDLE;
            cnt_d = itrsi_pkg::CNT_ZERO;
            busy_d = 1'b0;
            addressed_d = 1'b0;
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
        end
    end
    // ----------------------------------------
    // flags: a hardware set beats a same-cycle clear
    // ----------------------------------------
    assign receive_ready_flag_d = byte_done | (receive_ready_flag_q & ~ast_clr[itrsi_pkg::AST_RECEIVE_READY_FLAG]); // [R3]
    assign unread_d = byte_done | (unread_q & ~rd_rx);
    assign ovf_d = (byte_done & unread_q) | (ovf_q & ~evt_clr[itrsi_pkg::EVT_OVF]); // [R6]
    assign stop_seen_d = stop_set | (stop_seen_q & ~evt_clr[itrsi_pkg::EVT_STOP]); // [R11]
    assign mism_d = mism_set | (mism_q & ~evt_clr[itrsi_pkg::EVT_MISMATCH]);
    // a write while the clear bit is up stores data but leaves empty set
    assign transmit_empty_flag_d = transmit_empty_flag_set
        | (transmit_empty_flag_q & ~(wr_tx & ~ctl_q[itrsi_pkg::CTL_TBUF_CLR])); // [R14]
    assign tx_d = wr_tx ? pwdata[7:0] : (ctl_q[itrsi_pkg::CTL_TBUF_CLR] ? 8'h00 : tx_q);
    // soft reset wipes every other control bit while it is held
    assign ctl_d = ctl_w[itrsi_pkg::CTL_SOFTRST] ? itrsi_pkg::CTL_SOFTRST_VALUE : ctl_w;
    assign irq_d = (transmit_empty_flag_q & addressed_q & rw_q & ien_q[itrsi_pkg::IEN_TX]) // [R14]
        | (receive_ready_flag_q & ien_q[itrsi_pkg::IEN_RX]) // [R16]
        | (summary & ien_q[itrsi_pkg::IEN_BUS]); // [R15] [R18] [R20]
    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= itrsi_pkg::ST_IDLE;
            cnt_q <= itrsi_pkg::CNT_ZERO;
            shift_q <= 8'h00;
            match_q <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            busy_q <= 1'b0;
            addressed_q <= 1'b0;
            rw_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            match_q <= match_d;
            sda_oe_q <= sda_oe_d;
            scl_oe_q <= scl_oe_d;
            busy_q <= busy_d;
            addressed_q <= addressed_d;
            rw_q <= rw_d;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_q <= 8'h00;
            receive_ready_flag_q <= 1'b0;
            unread_q <= 1'b0;
            ovf_q <= 1'b0;
            stop_seen_q <= 1'b0;
            mism_q <= 1'b0;
            transmit_empty_flag_q <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            rx_q <= byte_done ? shift_d : rx_q; // [R2]
            receive_ready_flag_q <= receive_ready_flag_d;
            unread_q <= unread_d;
            ovf_q <= ovf_d;
            stop_seen_q <= stop_seen_d;
            mism_q <= mism_d;
            transmit_empty_flag_q <= transmit_empty_flag_d;
            irq <= irq_d;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_q <= 8'h00;
            own_q <= 7'h00;
            ctl_q <= itrsi_pkg::CTL_RESET;
            ien_q <= 3'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            tx_q <= tx_d;
            own_q <= (wr_w & sel_own) ? pwdata[6:0] : own_q;
            ctl_q <= ctl_d;
            ien_q <= (wr_w & sel_ien) ? pwdata[2:0] : ien_q; // [R15]
            pready_q <= setup_w;
            pslverr_q <= setup_w & ~mapped;
            prdata_q <= (setup_w & ~pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
    assign serial_clock_pin_oe = scl_oe_q;
    assign serial_data_pin_oe = sda_oe_q;
    // open drain: only ever pulls low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_clock_pin_out <= 1'b0;
            serial_data_pin_out <= 1'b0;
        end
        else
        begin
            serial_clock_pin_out <= 1'b0;
            serial_data_pin_out <= 1'b0;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_byte_in;
        byte_done && !proto_off;
    endsequence
    sequence s_addr_stop;
        stop_p && addressed_q && !proto_off;
    endsequence
    sequence s_ack_edge;
        state_q == itrsi_pkg::ST_RX && scl_fall && cnt_q == itrsi_pkg::CNT_BYTE
            && !start_p && !stop_p && !proto_off;
    endsequence
    rx_load_a: assert property (s_byte_in |=> receive_ready_flag_q && unread_q && rx_q == $past(shift_d)) // [R2]
        else $error("byte not loaded with ready");
    rx_gate_a: assert property ($rose(receive_ready_flag_q) |-> $past(addressed_q) && !$past(rw_q)) // [R1]
        else $error("byte received while not write-addressed");
    rdy_clear_a: assert property (wr_w && sel_ast && pwdata[itrsi_pkg::AST_RECEIVE_READY_FLAG] // [R3]
        && !byte_done |=> !receive_ready_flag_q)
        else $error("ready flag not cleared by write one");
    ovf_set_a: assert property (s_byte_in ##0 unread_q |=> ovf_q && receive_ready_flag_q) // [R6]
        else $error("overflow not flagged");
    stretch_hold_a: assert property (scl_oe_q && unread_q && !start_p && !stop_p // [R5]
        && !proto_off |=> scl_oe_q)
        else $error("clock released before read");
    ack_drive_a: assert property (s_ack_edge |=> sda_oe_q == !$past(ctl_q[itrsi_pkg::CTL_NAK])) // [R7]
        else $error("wrong acknowledge level");
    stop_release_a: assert property (s_addr_stop |=> stop_seen_q && !addressed_q && !busy_q // [R10]
        && !sda_oe_q && !scl_oe_q && state_q == itrsi_pkg::ST_IDLE)
        else $error("stop handling incomplete");
    stop_keep_a: assert property (stop_seen_q && !evt_clr[itrsi_pkg::EVT_STOP] |=> stop_seen_q) // [R11]
        else $error("stop flag dropped");
    rstart_flag_a: assert property (start_p && addressed_q && !proto_off // [R12]
        |=> stop_seen_q && busy_q && !addressed_q)
        else $error("repeated start not flagged");
    irq_mask_a: assert property (ien_q == 3'h0 [*2] |-> !irq) // [R15]
        else $error("interrupt without enable");
    bus_irq_a: assert property (summary && ien_q[itrsi_pkg::IEN_BUS] |=> irq) // [R18]
        else $error("bus event interrupt missing");
    rx_irq_a: assert property (s_byte_in ##1 ien_q[itrsi_pkg::IEN_RX] |=> irq) // [R16]
        else $error("receive interrupt missing");
    mism_mode_a: assert property ($rose(mism_q) |-> !$past(ctl_q[itrsi_pkg::CTL_ASYNC])) // [R19]
        else $error("mismatch in async mode");
endmodule
`default_nettype wire

// >>> rtl/itrsi_pkg.sv
`default_nettype none
package itrsi_pkg;
    // ----------------------------------------
    // register offsets (indices, byte address is four times)
    // ----------------------------------------
    localparam logic [15:0] OFS_TRANSMIT = 16'h4360;
    localparam logic [15:0] OFS_RECEIVE = 16'h4362;
    localparam logic [15:0] OFS_OWN_ADDR = 16'h4364;
    localparam logic [15:0] OFS_CONTROL = 16'h4366;
    localparam logic [15:0] OFS_BUS_EVENT = 16'h4368;
    localparam logic [15:0] OFS_ACCESS = 16'h436A;
    localparam logic [15:0] OFS_IRQ_EN = 16'h436C;
    localparam int ADDR_W = 17;
    localparam int REG_W = 16;
    localparam int CTL_W = 9;
    // ----------------------------------------
    // control fields
    // ----------------------------------------
    localparam int CTL_COMM = 0;
    localparam int CTL_ASYNC = 1;
    localparam int CTL_FILTER = 2;
    localparam int CTL_STRETCH = 3;
    localparam int CTL_BUS_FREE_REQUEST_FLAG = 4;
    localparam int CTL_NAK = 5;
    localparam int CTL_SOFTRST = 6;
    localparam int CTL_ENABLE = 7;
    localparam int CTL_TBUF_CLR = 8;
    localparam logic [8:0] CTL_RESET = 9'h000;
    localparam logic [8:0] CTL_SOFTRST_VALUE = 9'h040;
    // ----------------------------------------
    // bus event and access state fields
    // ----------------------------------------
    localparam int EVT_STOP = 0;
    localparam int EVT_CNAK = 1;
    localparam int EVT_ASYNC = 2;
    localparam int EVT_MISMATCH = 3;
    localparam int EVT_BUS_FREE_REQUEST_FLAG = 4;
    localparam int EVT_OVF = 5;
    localparam int EVT_SUMMARY = 7;
    localparam int AST_RW = 0;
    localparam int AST_ADDRESSED = 1;
    localparam int AST_BUSY = 2;
    localparam int AST_TRANSMIT_EMPTY_FLAG = 3;
    localparam int AST_RECEIVE_READY_FLAG = 4;
    localparam int IEN_TX = 0;
    localparam int IEN_RX = 1;
    localparam int IEN_BUS = 2;
    // ----------------------------------------
    // serial framing
    // ----------------------------------------
    localparam logic [3:0] CNT_LAST_BIT = 4'h7;
    localparam logic [3:0] CNT_BYTE = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_RX = 3'b011,
        ST_RX_ACK = 3'b100,
        ST_HOLD = 3'b101
    } itrsi_state_e;
endpackage
`default_nettype wire

// >>> rtl/itrsi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module itrsi_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // lines
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // ----------------------------------------
    // two-stage synchroniser per line
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic meta_q;
            // reset high: an idle bus rests released
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_q <= 1'b1;
                    q[i] <= 1'b1;
                end
                else
                begin
                    meta_q <= d[i];
                    q[i] <= meta_q;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> rtl/itrsi_linecond.sv
`timescale 1ns/1ps
`default_nettype none
module itrsi_linecond (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // synchronised lines
    input wire logic scl,
    input wire logic sda,
    // events
    output logic scl_rise,
    output logic scl_fall,
    output logic start_p,
    output logic stop_p
);
    logic scl_q;
    logic sda_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    assign scl_rise = scl & ~scl_q;
    assign scl_fall = ~scl & scl_q;
    // data edges count only while clock stays high over both samples
    assign start_p = scl & scl_q & sda_q & ~sda;
    assign stop_p = scl & scl_q & ~sda_q & sda; // [R9]
endmodule
`default_nettype wire

// >>> tb/itrsi_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module itrsi_ctrl_model (
    // clock
    input wire logic pclk,
    // bus wires, open drain
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one bit: 4 pclk low, 4 high, 80 ns
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        tick(4);
        scl_low <= 1'b0;
        while (!scl) tick(1); // stretch is honoured, the bench watchdog bounds it
        tick(1);
        r = sda;
        tick(2);
        scl_low <= 1'b1;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r); // msb first
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // another target acknowledges an address that is not ours
    task automatic send_foreign(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b0, r);
    endtask
    task automatic start;
        sda_low <= 1'b1;
        tick(4);
        scl_low <= 1'b1;
        tick(4);
    endtask
    // waits past the target's ack release so no false stop appears
    task automatic restart;
        sda_low <= 1'b0;
        tick(6);
        scl_low <= 1'b0;
        tick(4);
        start();
    endtask
    task automatic stop;
        sda_low <= 1'b1;
        tick(6);
        scl_low <= 1'b0;
        tick(4);
        sda_low <= 1'b0; // data rises while clock high
        tick(4);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, err, ack;
    logic scl_oe, sda_oe, m_scl, m_sda;
    logic [16:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int fails, checked;
    wire scl = !(m_scl | scl_oe);
    wire sda = !(m_sda | sda_oe);
    always #5 pclk = !pclk;
    itrsi_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clock_pin_in(scl), .serial_clock_pin_out(),
        .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda), .serial_data_pin_out(),
        .serial_data_pin_oe(sda_oe), .irq(irq));
    itrsi_ctrl_model u_m (.pclk(pclk), .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] o, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {o[14:0], 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no fixed wait count: only the watchdog ends a hung access
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next call never re-raises psel in this time step
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [15:0] o, input logic [31:0] e);
        apb(1'b0, o, 32'h0);
        chk($sformatf("reg %h", o), rd, e);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        fails++;
        conclude();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        u_m.tick(4);
        rdc(itrsi_pkg::OFS_IRQ_EN, 32'h0);
        apb(1'b0, 16'h4370, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        apb(1'b1, itrsi_pkg::OFS_OWN_ADDR, 32'h2A);
        apb(1'b1, itrsi_pkg::OFS_CONTROL, 32'h81);
        apb(1'b1, itrsi_pkg::OFS_IRQ_EN, 32'h7);
        // address and first byte
        u_m.start();
        u_m.send(8'h54, ack);
        chk("addr ack", ack, 1);
        rdc(itrsi_pkg::OFS_ACCESS, 32'h6);
        u_m.send(8'hA5, ack);
        chk("data ack", ack, 1);
        chk("irq rx", irq, 1);
        rdc(itrsi_pkg::OFS_ACCESS, 32'h16);
        rdc(itrsi_pkg::OFS_RECEIVE, 32'hA5);
        apb(1'b1, itrsi_pkg::OFS_ACCESS, 32'h10);
        rdc(itrsi_pkg::OFS_ACCESS, 32'h6);
        // overrun, then answer with nak
        u_m.send(8'h11, ack);
        u_m.send(8'h22, ack);
        rdc(itrsi_pkg::OFS_BUS_EVENT, 32'hA0);
        rdc(itrsi_pkg::OFS_RECEIVE, 32'h22);
        apb(1'b1, itrsi_pkg::OFS_BUS_EVENT, 32'h20);
        apb(1'b1, itrsi_pkg::OFS_ACCESS, 32'h10);
        rdc(itrsi_pkg::OFS_BUS_EVENT, 32'h0);
        apb(1'b1, itrsi_pkg::OFS_CONTROL, 32'hA1);
        u_m.send(8'h33, ack);
        chk("nak", ack, 0);
        apb(1'b1, itrsi_pkg::OFS_CONTROL, 32'h81);
        rdc(itrsi_pkg::OFS_RECEIVE, 32'h33);
        apb(1'b1, itrsi_pkg::OFS_ACCESS, 32'h10);
        // repeated start while addressed
        u_m.restart();
        u_m.send(8'h54, ack);
        rdc(itrsi_pkg::OFS_BUS_EVENT, 32'h81);
        rdc(itrsi_pkg::OFS_BUS_EVENT, 32'h81);
        apb(1'b1, itrsi_pkg::OFS_BUS_EVENT, 32'h1);
        rdc(itrsi_pkg::OFS_BUS_EVENT, 32'h0);
        // stretch until read, then stop
        apb(1'b1, itrsi_pkg::OFS_CONTROL, 32'h89);
        fork
            u_m.send(8'h77, ack);
            begin
                u_m.tick(90);
                chk("stretch", scl_oe, 1);
                rdc(itrsi_pkg::OFS_RECEIVE, 32'h77);
            end
        join
        chk("stretch ack", ack, 1);
        apb(1'b1, itrsi_pkg::OFS_ACCESS, 32'h10);
        u_m.stop();
        rdc(itrsi_pkg::OFS_BUS_EVENT, 32'h81);
        rdc(itrsi_pkg::OFS_ACCESS, 32'h0);
        chk("lines", {scl_oe, sda_oe}, 0);
        chk("irq bus", irq, 1);
        apb(1'b1, itrsi_pkg::OFS_IRQ_EN, 32'h0);
        u_m.tick(2);
        chk("irq off", irq, 0);
        // read request, then an address that another target acknowledges
        apb(1'b1, itrsi_pkg::OFS_BUS_EVENT, 32'h1);
        apb(1'b1, itrsi_pkg::OFS_IRQ_EN, 32'h1);
        u_m.start();
        u_m.send(8'h55, ack);
        chk("rd addr ack", ack, 1);
        u_m.tick(4);
        rdc(itrsi_pkg::OFS_ACCESS, 32'hF);
        chk("irq tx", irq, 1);
        apb(1'b1, itrsi_pkg::OFS_TRANSMIT, 32'h3C);
        rdc(itrsi_pkg::OFS_ACCESS, 32'h7);
        chk("irq tx off", irq, 0);
        u_m.restart();
        u_m.send_foreign(8'hA0);
        u_m.stop();
        rdc(itrsi_pkg::OFS_BUS_EVENT, 32'h89);
        rdc(itrsi_pkg::OFS_ACCESS, 32'h1);
        apb(1'b1, itrsi_pkg::OFS_CONTROL, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
